// *** hdl/wcb_bank.sv ***
// Comparator bank with rate generator and active target record
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
module wcb_bank (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic srst_in,
	// Register port
	input wire wcb_pkg::wcb_req_type req_in,
	output logic [31:0] rdata_out,
	// Source samples
	input wire wcb_pkg::wcb_smp_type smp_in,
	// Discrete outputs and interrupt
	output logic [wcb_pkg::NUM_OUT-1:0] discrete_out,
	output logic irq_out
);
	import wcb_pkg::*;

	typedef struct packed {
		wcb_chan_type [NUM_CH-1:0] ch;
		wcb_rec_type [NUM_TBL-1:0] tbl;
		logic [NUM_FLD-1:0][31:0] pend;
		logic [NUM_FLD-1:0][31:0] act;
		logic [7:0] act_id;
		wcb_mode_type mode;
		logic [2:0] ctrl;
		logic [15:0] rate_per;
		logic [2:0] rate_avg;
		logic [15:0] rate_cnt;
		logic [31:0] rate_acc;
		logic [7:0] rate_n;
		logic [31:0] gross_last;
		logic [31:0] gross_prev;
		logic prev_seen;
		logic [31:0] rate_val;
		logic rate_vld;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_en;
		logic [3:0] tbl_sel;
		logic [NUM_OUT-1:0] outs;
		logic [31:0] rdata;
		logic irq;
	} wcb_state_type;

	wcb_state_type s_r;
	wcb_state_type s_nxt;

	// Comparison of one sample against limit and high limit
	function automatic logic cmp_fn(input wcb_op_type op, input logic signed [31:0] x,
		input logic signed [31:0] lo, input logic signed [31:0] hi);
		logic r;
		r = 1'b0;
		case (op)
			WCB_OP_LT: r = x < lo;
			WCB_OP_LE: r = x <= lo;
			WCB_OP_EQ: r = x == lo;
			WCB_OP_NE: r = x != lo;
			WCB_OP_GE: r = x >= lo;
			WCB_OP_GT: r = x > lo;
			WCB_OP_WITHIN: r = (x >= lo) && (x <= hi);
			WCB_OP_OUTSIDE: r = (x < lo) || (x > hi);
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// Number of fields a record holds in a mode
	function automatic logic [2:0] fld_cnt_fn(input wcb_mode_type m);
		logic [2:0] n;
		n = 3'h5;
		case (m)
			WCB_MODE_XFER: n = 3'h5;
			WCB_MODE_OU_DEV: n = 3'h3;
			WCB_MODE_OU_VAL: n = 3'h2;
			default: n = 3'h5;
		endcase
		return n;
	endfunction

	// Clears the fields that the mode does not use
	function automatic logic [NUM_FLD-1:0][31:0] fld_mask_fn(input wcb_mode_type m,
		input logic [NUM_FLD-1:0][31:0] f);
		logic [NUM_FLD-1:0][31:0] o;
		o = f;
		for (int i = 0; i < NUM_FLD; i++) begin
			if (3'(i) >= fld_cnt_fn(m)) begin
				o[i] = 32'h0;
			end
		end
		return o;
	endfunction

	// Hit in a five-word field block at the given base
	function automatic logic fblk_hit_fn(input logic [9:0] a, input logic [9:0] base);
		logic h;
		h = (a[9:5] == base[9:5]) && (a[4:2] < 3'(NUM_FLD));
		return h;
	endfunction

	// Hit in the channel register window
	function automatic logic ch_hit_fn(input logic [9:0] a);
		logic h;
		h = (a >= A_CH_BASE) && (a < A_CH_END);
		return h;
	endfunction

	// Next-state logic
	always_comb begin
		logic [9:0] ch_off;
		logic [4:0] chi;
		logic [2:0] fi;
		logic [IRQ_W-1:0] set;
		logic [IRQ_W-1:0] clr;
		logic [31:0] x;
		logic vld;
		logic found;
		logic [3:0] hit;
		logic [7:0] lid;
		logic [15:0] per;
		logic [31:0] diff;
		logic [31:0] acc;
		ch_off = 10'h0;
		chi = 5'h0;
		fi = 3'h0;
		set = '0;
		clr = '0;
		x = 32'h0;
		vld = 1'b0;
		found = 1'b0;
		hit = 4'h0;
		lid = 8'h0;
		per = 16'h0;
		diff = 32'h0;
		acc = 32'h0;
		s_nxt = s_r;
		s_nxt.rdata = 32'h0;
		s_nxt.rate_vld = 1'b0;
		// Channel and field index from the address
		ch_off = req_in.addr - A_CH_BASE;
		chi = ch_off[8:4];
		fi = req_in.addr[4:2];

		// Rate generator: difference of gross samples per period, averaged
		if (smp_in.gross_vld) begin
			s_nxt.gross_last = smp_in.gross;
		end
		// A zero period is taken as one cycle
		per = (s_r.rate_per == 16'h0) ? 16'h1 : s_r.rate_per;
		// Disabled generator forgets its history, so the first capture only primes
		if (!s_r.ctrl[CTRL_RATE_EN]) begin
			s_nxt.rate_cnt = 16'h0;
			s_nxt.rate_acc = 32'h0;
			s_nxt.rate_n = 8'h0;
			s_nxt.prev_seen = 1'b0;
		end else if (s_r.rate_cnt + 16'h1 >= per) begin
			s_nxt.rate_cnt = 16'h0;
			s_nxt.gross_prev = s_r.gross_last;
			s_nxt.prev_seen = 1'b1;
			// A capture with no earlier partner gives no difference
			if (s_r.prev_seen) begin
				diff = s_r.gross_last - s_r.gross_prev;
				acc = s_r.rate_acc + diff;
				// A full group of 2^n differences yields one averaged rate
				if (s_r.rate_n + 8'h1 >= (8'h1 << s_r.rate_avg)) begin
					s_nxt.rate_val = $signed(acc) >>> s_r.rate_avg;
					s_nxt.rate_vld = 1'b1;
					s_nxt.rate_acc = 32'h0;
					s_nxt.rate_n = 8'h0;
				end else begin
					s_nxt.rate_acc = acc;
					s_nxt.rate_n = s_r.rate_n + 8'h1;
				end
			end
		end else begin
			s_nxt.rate_cnt = s_r.rate_cnt + 16'h1;
		end

		// Register writes
		if (req_in.wr) begin
			case (req_in.addr)
				A_CTRL: s_nxt.ctrl = req_in.wdata[2:0];
				A_RATE_PER: s_nxt.rate_per = req_in.wdata[15:0];
				A_RATE_AVG: s_nxt.rate_avg = req_in.wdata[2:0];
				A_IRQ_CLR: clr = req_in.wdata[IRQ_W-1:0];
				A_IRQ_EN: s_nxt.irq_en = req_in.wdata[IRQ_W-1:0];
				A_TBL_SEL: s_nxt.tbl_sel = req_in.wdata[3:0];
				A_TGT_MODE: begin
					if (s_r.ctrl[CTRL_SETUP]) begin
						s_nxt.mode = wcb_mode_type'(req_in.wdata[1:0]);
					end
				end
				A_TBL_ID: begin
					s_nxt.tbl[s_r.tbl_sel].id = req_in.wdata[7:0];
					s_nxt.tbl[s_r.tbl_sel].vld = req_in.wdata[TBL_VLD_BIT];
				end
				A_TGT_CMD: begin
					lid = req_in.wdata[CMD_ID_LSB +: 8];
					// Load beats accept, accept beats escape
					if (req_in.wdata[CMD_LOAD]) begin
						// Lowest valid matching entry wins
						for (int t = 0; t < NUM_TBL; t++) begin
							if (s_r.tbl[t].vld && s_r.tbl[t].id == lid && !found) begin
								found = 1'b1;
								hit = 4'(t);
							end
						end
						if (found) begin
							s_nxt.act = fld_mask_fn(s_r.mode, s_r.tbl[hit].fld);
							s_nxt.pend = fld_mask_fn(s_r.mode, s_r.tbl[hit].fld);
							s_nxt.act_id = lid;
							set[IRQ_LOADED] = 1'b1;
						end else begin
							// A miss leaves the active record and its ID untouched
							set[IRQ_NOT_FOUND] = 1'b1;
						end
					end else if (req_in.wdata[CMD_ACCEPT]) begin
						s_nxt.act = fld_mask_fn(s_r.mode, s_r.pend);
						s_nxt.pend = fld_mask_fn(s_r.mode, s_r.pend);
						set[IRQ_ACCEPTED] = 1'b1;
					end else if (req_in.wdata[CMD_ESCAPE]) begin
						s_nxt.pend = s_r.act;
					end
				end
				default: begin
					// Pending fields beyond the mode's count are refused
					if (fblk_hit_fn(req_in.addr, A_PEND_BASE)) begin
						if (fi < fld_cnt_fn(s_r.mode)) begin
							s_nxt.pend[fi] = req_in.wdata;
						end
					end else if (fblk_hit_fn(req_in.addr, A_TBLF_BASE)) begin
						s_nxt.tbl[s_r.tbl_sel].fld[fi] = req_in.wdata;
					end else if (ch_hit_fn(req_in.addr)) begin
						// Limits stay writable outside setup; configuration needs setup
						case (ch_off[3:0])
							CH_CFG: begin
								if (s_r.ctrl[CTRL_SETUP]) begin
									s_nxt.ch[chi].cfg = req_in.wdata[23:0];
								end
							end
							CH_LIMIT: s_nxt.ch[chi].lo = req_in.wdata;
							CH_HIGH: s_nxt.ch[chi].hi = req_in.wdata;
							default: ;
						endcase
					end
				end
			endcase
		end

		// Channel evaluation on a fresh sample of the selected source
		for (int c = 0; c < NUM_CH; c++) begin
			case (s_r.ch[c].cfg.src)
				WCB_SRC_GROSS: begin
					x = smp_in.gross;
					vld = smp_in.gross_vld;
				end
				WCB_SRC_DISP: begin
					x = smp_in.disp;
					vld = smp_in.disp_vld;
				end
				WCB_SRC_RATE: begin
					x = s_r.rate_val;
					vld = s_r.rate_vld;
				end
				default: begin
					x = smp_in.custom;
					vld = smp_in.custom_vld;
				end
			endcase
			// Rate channels hold off unless rate is both calculated and shown
			if (s_r.ch[c].cfg.src == WCB_SRC_RATE &&
				!(s_r.ctrl[CTRL_RATE_EN] && s_r.ctrl[CTRL_RATE_DISP])) begin
				s_nxt.ch[c].res = 1'b0;
			end else if (vld) begin
				// A result holds until its source brings a new sample
				s_nxt.ch[c].res = cmp_fn(s_r.ch[c].cfg.op, x, s_r.ch[c].lo,
					s_r.ch[c].hi);
			end
		end

		// Outputs are the OR of channels assigned to them
		s_nxt.outs = '0;
		for (int c = 0; c < NUM_CH; c++) begin
			for (int o = 0; o < NUM_OUT; o++) begin
				if (s_r.ch[c].cfg.outsel == 5'(o + 1) && s_nxt.ch[c].res) begin
					s_nxt.outs[o] = 1'b1;
				end
			end
		end
		// Any change of the output pattern is a status event
		if (s_nxt.outs != s_r.outs) begin
			set[IRQ_OUT_CHG] = 1'b1;
		end

		// Sticky status: a new event beats a clear
		s_nxt.irq_st = (s_r.irq_st & ~clr) | set;
		// Interrupt follows status and enable at the same edge
		s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_en);

		// Register reads
		if (req_in.rd) begin
			case (req_in.addr)
				A_CTRL: s_nxt.rdata = {29'h0, s_r.ctrl};
				A_RATE_PER: s_nxt.rdata = {16'h0, s_r.rate_per};
				A_RATE_AVG: s_nxt.rdata = {29'h0, s_r.rate_avg};
				A_RATE_VAL: s_nxt.rdata = s_r.rate_val;
				A_IRQ_ST: s_nxt.rdata = {28'h0, s_r.irq_st};
				A_IRQ_EN: s_nxt.rdata = {28'h0, s_r.irq_en};
				A_OUT_ST: s_nxt.rdata = {24'h0, s_r.outs};
				A_TGT_MODE: s_nxt.rdata = {30'h0, s_r.mode};
				A_TGT_ACT_ID: s_nxt.rdata = {24'h0, s_r.act_id};
				A_TBL_SEL: s_nxt.rdata = {28'h0, s_r.tbl_sel};
				default: begin
					// Write-only and unmapped addresses read as zero
					if (fblk_hit_fn(req_in.addr, A_PEND_BASE)) begin
						s_nxt.rdata = s_r.pend[fi];
					end else if (fblk_hit_fn(req_in.addr, A_ACT_BASE)) begin
						s_nxt.rdata = s_r.act[fi];
					end else if (ch_hit_fn(req_in.addr)) begin
						case (ch_off[3:0])
							CH_CFG: s_nxt.rdata = {8'h0, s_r.ch[chi].cfg};
							CH_LIMIT: s_nxt.rdata = s_r.ch[chi].lo;
							CH_HIGH: s_nxt.rdata = s_r.ch[chi].hi;
							CH_RES: s_nxt.rdata = {31'h0, s_r.ch[chi].res};
							default: s_nxt.rdata = 32'h0;
						endcase
					end
				end
			endcase
		end
	end

	// State register
	// Synchronous reset clears the whole state to zero
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			s_r <= {$bits(wcb_state_type){RST_VAL}};
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign rdata_out = s_r.rdata;
	assign discrete_out = s_r.outs;
	assign irq_out = s_r.irq;
endmodule

// *** common/wcb_pkg.sv ***
// Package of constants and types for the weight comparator bank
//
// Functional notes
// - Twenty channels, each with own identifier, limit, high limit and operator.
// - Each channel selects gross, displayed, rate or custom source.
// - Relational operators compare the source against the limit only.
// - Within and outside operators compare against limit and high limit range.
// - Results act only through the assigned discrete output; unassigned does nothing.
// - Less-than output is on below the limit, off once limit reached.
// - In range mode limit is the lower bound, high limit the upper.
// - Within output active between bounds, off below lower or above upper.
// - Outside output active below lower or above upper, inactive between.
// - Rate channels compare only with rate calculation enabled and rate display on.
// - Rate comes from samples at set period, averaged over set count.
// - In operation only limits change; other channel parameters need setup mode.
// - Unknown target ID flags not-found and keeps the loaded record.
// - Active record fields depend on mode: five, three or two fields.
// - Record edits stay pending, accept commits them all, escape discards them.
package wcb_pkg;
	localparam int NUM_CH = 20;
	localparam int NUM_TBL = 16;
	localparam int NUM_FLD = 5;
	localparam int NUM_OUT = 8;
	// Register byte addresses
	localparam logic [9:0] A_CTRL = 10'h000;
	localparam logic [9:0] A_RATE_PER = 10'h004;
	localparam logic [9:0] A_RATE_AVG = 10'h008;
	localparam logic [9:0] A_RATE_VAL = 10'h00c;
	localparam logic [9:0] A_IRQ_ST = 10'h010;
	localparam logic [9:0] A_IRQ_CLR = 10'h014;
	localparam logic [9:0] A_IRQ_EN = 10'h018;
	localparam logic [9:0] A_OUT_ST = 10'h01c;
	localparam logic [9:0] A_TGT_MODE = 10'h020;
	localparam logic [9:0] A_TGT_CMD = 10'h024;
	localparam logic [9:0] A_TGT_ACT_ID = 10'h028;
	localparam logic [9:0] A_TBL_SEL = 10'h02c;
	localparam logic [9:0] A_TBL_ID = 10'h030;
	localparam logic [9:0] A_PEND_BASE = 10'h040;
	localparam logic [9:0] A_ACT_BASE = 10'h060;
	localparam logic [9:0] A_TBLF_BASE = 10'h080;
	localparam logic [9:0] A_CH_BASE = 10'h100;
	localparam logic [9:0] A_CH_END = 10'h240;
	localparam logic [3:0] CH_CFG = 4'h0;
	localparam logic [3:0] CH_LIMIT = 4'h4;
	localparam logic [3:0] CH_HIGH = 4'h8;
	localparam logic [3:0] CH_RES = 4'hc;
	// Field positions
	localparam int CTRL_SETUP = 0;
	localparam int CTRL_RATE_EN = 1;
	localparam int CTRL_RATE_DISP = 2;
	localparam int CMD_ACCEPT = 0;
	localparam int CMD_ESCAPE = 1;
	localparam int CMD_LOAD = 2;
	localparam int CMD_ID_LSB = 8;
	localparam int TBL_VLD_BIT = 8;
	localparam int IRQ_NOT_FOUND = 0;
	localparam int IRQ_LOADED = 1;
	localparam int IRQ_ACCEPTED = 2;
	localparam int IRQ_OUT_CHG = 3;
	localparam int IRQ_W = 4;
	// Reset value of the whole state
	localparam logic RST_VAL = 1'b0;
	typedef enum logic [1:0] {
		WCB_SRC_GROSS = 2'b00,
		WCB_SRC_DISP = 2'b01,
		WCB_SRC_RATE = 2'b10,
		WCB_SRC_CUSTOM = 2'b11
	} wcb_src_type;
	typedef enum logic [3:0] {
		WCB_OP_OFF = 4'h0,
		WCB_OP_LT = 4'h1,
		WCB_OP_LE = 4'h2,
		WCB_OP_EQ = 4'h3,
		WCB_OP_NE = 4'h4,
		WCB_OP_GE = 4'h5,
		WCB_OP_GT = 4'h6,
		WCB_OP_WITHIN = 4'h7,
		WCB_OP_OUTSIDE = 4'h8
	} wcb_op_type;
	typedef enum logic [1:0] {
		WCB_MODE_XFER = 2'b00,
		WCB_MODE_OU_DEV = 2'b01,
		WCB_MODE_OU_VAL = 2'b10
	} wcb_mode_type;
	// Channel configuration word: id 23:16, out 10:6, op 5:2, src 1:0
	typedef struct packed {
		logic [7:0] uid;
		logic [4:0] rsv;
		logic [4:0] outsel;
		wcb_op_type op;
		wcb_src_type src;
	} wcb_cfg_type;
	typedef struct packed {
		wcb_cfg_type cfg;
		logic [31:0] lo;
		logic [31:0] hi;
		logic res;
	} wcb_chan_type;
	typedef struct packed {
		logic vld;
		logic [7:0] id;
		logic [NUM_FLD-1:0][31:0] fld;
	} wcb_rec_type;
	// Register port request
	typedef struct packed {
		logic [9:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} wcb_req_type;
	// Weight samples from the front end
	typedef struct packed {
		logic [31:0] gross;
		logic gross_vld;
		logic [31:0] disp;
		logic disp_vld;
		logic [31:0] custom;
		logic custom_vld;
	} wcb_smp_type;
endpackage

// *** test/wcb_bank_monitor.sv ***
// Port-level checker for the comparator bank
`timescale 1ns/1ps
module wcb_bank_monitor (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic srst_in,
	// Register port
	input wire wcb_pkg::wcb_req_type req_in,
	input wire logic [31:0] rdata_out,
	// Samples, outputs and interrupt
	input wire wcb_pkg::wcb_smp_type smp_in,
	input wire logic [wcb_pkg::NUM_OUT-1:0] discrete_out,
	input wire logic irq_out
);
	import wcb_pkg::*;
	logic cfg_seen_r;
	logic rate_seen_r;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);
	// Remember channel writes and rate enabling since reset
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			cfg_seen_r <= 1'b0;
			rate_seen_r <= 1'b0;
		end else begin
			if (req_in.wr && req_in.addr >= A_CH_BASE && req_in.addr < A_CH_END)
				cfg_seen_r <= 1'b1;
			if (req_in.wr && req_in.addr == A_CTRL && req_in.wdata[CTRL_RATE_EN])
				rate_seen_r <= 1'b1;
		end
	end
	// Command then immediate status read; all enables cleared, then no enable write
	sequence s_load_st;
		req_in.wr && req_in.addr == A_TGT_CMD && req_in.wdata[CMD_LOAD]
		##1 req_in.rd && req_in.addr == A_IRQ_ST;
	endsequence
	sequence s_acc_st;
		req_in.wr && req_in.addr == A_TGT_CMD && req_in.wdata[2:0] == 3'h1
		##1 req_in.rd && req_in.addr == A_IRQ_ST;
	endsequence
	sequence s_en_off;
		req_in.wr && req_in.addr == A_IRQ_EN && req_in.wdata[3:0] == 4'h0
		##1 !(req_in.wr && req_in.addr == A_IRQ_EN);
	endsequence
	property p_rd_idle;
		!$past(req_in.rd) |-> rdata_out == 32'h0;
	endproperty
	property p_wo_zero;
		req_in.rd && (req_in.addr == A_IRQ_CLR || req_in.addr == A_TGT_CMD) |=> rdata_out == 32'h0;
	endproperty
	property p_out_quiet;
		!cfg_seen_r |-> discrete_out == '0;
	endproperty
	property p_out_cause;
		$changed(discrete_out) |-> rate_seen_r || $past(smp_in.gross_vld || smp_in.disp_vld
			|| smp_in.custom_vld || srst_in) || $past(req_in.wr, 2);
	endproperty
	property p_out_st;
		req_in.rd && req_in.addr == A_OUT_ST |=> rdata_out[NUM_OUT-1:0] == $past(discrete_out);
	endproperty
	property p_load_flag;
		s_load_st |=> rdata_out[IRQ_NOT_FOUND] || rdata_out[IRQ_LOADED];
	endproperty
	property p_acc_flag;
		s_acc_st |=> rdata_out[IRQ_ACCEPTED];
	endproperty
	property p_irq_off;
		s_en_off |=> !irq_out;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
	a_wo_zero: assert property (p_wo_zero) else $error("write-only reg read nonzero");
	a_out_quiet: assert property (p_out_quiet) else $error("output with no channel set");
	a_out_cause: assert property (p_out_cause) else $error("output moved without sample");
	a_out_st: assert property (p_out_st) else $error("output status differs");
	a_load_flag: assert property (p_load_flag) else $error("load left no flag");
	a_acc_flag: assert property (p_acc_flag) else $error("accept left no flag");
	a_irq_off: assert property (p_irq_off) else $error("masked interrupt high");
endmodule
bind wcb_bank wcb_bank_monitor wcb_bank_monitor_inst (.clk_sys_in(clk_sys_in),
	.srst_in(srst_in), .req_in(req_in), .rdata_out(rdata_out), .smp_in(smp_in),
	.discrete_out(discrete_out), .irq_out(irq_out));

// *** test/wcb_equip_model.sv ***
// Process equipment relays switched by the discrete outputs
`timescale 1ns/1ps
module wcb_equip_model (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic srst_in,
	// Coil drive from the bank
	input wire logic [7:0] drive_in,
	// Relay contacts and switching count
	output logic [7:0] relay_out,
	output logic [15:0] switch_cnt_out
);
	// Relays follow their coils one cycle late
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			relay_out <= 8'h00;
			switch_cnt_out <= 16'h0;
		end else begin
			relay_out <= drive_in;
			if (relay_out != drive_in)
				switch_cnt_out <= switch_cnt_out + 16'h1;
		end
	end
endmodule

// *** test/wcb_bank_tb_top.sv ***
// Self-checking bench for the comparator bank
`timescale 1ns/1ps
module wcb_bank_tb_top;
	import wcb_pkg::*;
	typedef struct {wcb_op_type op; wcb_src_type src; int lo; int hi; int x; logic ex;} wcb_row_type;
	logic clk_sys_in;
	logic srst_in;
	wcb_req_type req;
	wcb_smp_type smp;
	logic [31:0] rdata;
	logic [7:0] dout;
	logic irq;
	logic [7:0] relay;
	logic [15:0] sw_cnt;
	logic [31:0] d;
	int fails;
	int total_checks;
	int g;
	// Outside rows keep a wide gap above the lower bound
	wcb_row_type rows [13] = '{
		'{WCB_OP_LT, WCB_SRC_GROSS, 1000, 0, 999, 1'b1}, '{WCB_OP_LT, WCB_SRC_GROSS, 1000, 0, 1000, 1'b0},
		'{WCB_OP_LE, WCB_SRC_DISP, 5, 0, 5, 1'b1}, '{WCB_OP_EQ, WCB_SRC_DISP, 5, 0, 5, 1'b1},
		'{WCB_OP_NE, WCB_SRC_CUSTOM, 5, 0, 5, 1'b0}, '{WCB_OP_GE, WCB_SRC_CUSTOM, 5, 0, 4, 1'b0},
		'{WCB_OP_GT, WCB_SRC_GROSS, -3, 0, -2, 1'b1}, '{WCB_OP_WITHIN, WCB_SRC_GROSS, 3, 8, 3, 1'b1},
		'{WCB_OP_WITHIN, WCB_SRC_GROSS, 3, 8, 2, 1'b0}, '{WCB_OP_WITHIN, WCB_SRC_DISP, 3, 8, 9, 1'b0},
		'{WCB_OP_OUTSIDE, WCB_SRC_GROSS, 1000, 1500, 999, 1'b1},
		'{WCB_OP_OUTSIDE, WCB_SRC_CUSTOM, 1000, 1500, 1200, 1'b0},
		'{WCB_OP_OUTSIDE, WCB_SRC_GROSS, 1000, 1500, 1501, 1'b1}};
	wcb_bank wcb_bank_inst (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .req_in(req),
		.rdata_out(rdata), .smp_in(smp), .discrete_out(dout), .irq_out(irq));
	wcb_equip_model wcb_equip_model_inst (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
		.drive_in(dout), .relay_out(relay), .switch_cnt_out(sw_cnt));
	// Clock generation
	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	// Compare helpers
	task automatic chk_reg(input logic [31:0] e, input logic [31:0] a);
		total_checks++;
		if (a !== e) begin
			fails++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask
	task automatic chk_out(input logic [7:0] e, input logic [7:0] a);
		chk_reg({24'h0, e}, {24'h0, a});
	endtask
	// Register port cycles
	task automatic wr(input logic [9:0] a, input logic [31:0] v);
		@(posedge clk_sys_in);
		req <= '{a, v, 1'b1, 1'b0};
	endtask
	task automatic rd(input logic [9:0] a, output logic [31:0] v);
		@(posedge clk_sys_in);
		req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk_sys_in);
		req <= '0;
		#1;
		v = rdata;
	endtask
	task automatic rchk(input logic [9:0] a, input logic [31:0] e);
		rd(a, d);
		chk_reg(e, d);
	endtask
	// One sample on every source, then look after the edge
	task automatic smpl(input logic [31:0] gv, input logic [31:0] dv, input logic [31:0] cv);
		@(posedge clk_sys_in);
		req <= '0;
		smp <= '{gv, 1'b1, dv, 1'b1, cv, 1'b1};
		@(posedge clk_sys_in);
		smp <= '{gv, 1'b0, dv, 1'b0, cv, 1'b0};
		#1;
	endtask
	task automatic ramp();
		repeat (40) begin
			@(posedge clk_sys_in);
			req <= '0;
			smp <= '{g, 1'b1, 32'h0, 1'b0, 32'h0, 1'b0};
			g += 5;
		end
		@(posedge clk_sys_in);
		smp <= '0;
		#1;
	endtask
	function automatic logic [31:0] pick(input int x, input wcb_src_type s, input wcb_src_type w);
		return (s == w) ? x : x + 32'h100000;
	endfunction
	function automatic logic [9:0] cha(input int c, input logic [3:0] o);
		return A_CH_BASE + 10'(c * 16) + 10'(o);
	endfunction
	function automatic logic [31:0] cfgw(input wcb_op_type op, input wcb_src_type s,
		input logic [4:0] o);
		return {8'h00, 8'h5a, 5'h00, o, op, s};
	endfunction
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		fails++;
		final_report();
	end
	// Main sequence
	initial begin
		srst_in = 1'b1;
		req = '0;
		smp = '0;
		fails = 0;
		total_checks = 0;
		g = 0;
		repeat (6) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		rchk(A_OUT_ST, 32'h0);
		rchk(cha(19, CH_CFG), 32'h0);
		wr(A_CTRL, 32'h1);
		foreach (rows[i]) begin
			wr(cha(0, CH_LIMIT), rows[i].lo);
			wr(cha(0, CH_HIGH), rows[i].hi);
			wr(cha(0, CH_CFG), cfgw(rows[i].op, rows[i].src, 5'd1));
			smpl(pick(rows[i].x, rows[i].src, WCB_SRC_GROSS), pick(rows[i].x, rows[i].src,
				WCB_SRC_DISP), pick(rows[i].x, rows[i].src, WCB_SRC_CUSTOM));
			chk_out({7'h0, rows[i].ex}, dout);
			rchk(cha(0, CH_RES), {31'h0, rows[i].ex});
		end
		$display("test table done");
		// Unassigned channels drive nothing, the last channel drives output 8
		wr(cha(0, CH_CFG), 32'h0);
		wr(cha(1, CH_CFG), cfgw(WCB_OP_NE, WCB_SRC_GROSS, 5'd0));
		wr(cha(2, CH_CFG), cfgw(WCB_OP_NE, WCB_SRC_GROSS, 5'd9));
		wr(cha(19, CH_CFG), cfgw(WCB_OP_NE, WCB_SRC_GROSS, 5'd8));
		smpl(7, 7, 7);
		chk_out(8'h80, dout);
		rchk(cha(1, CH_RES), 32'h1);
		chk_out(8'h80, relay);
		// Eleven clean output changes so far, no glitches between samples
		chk_reg(32'd11, {16'h0, sw_cnt});
		// Outside setup only limits take effect
		wr(A_CTRL, 32'h0);
		wr(cha(19, CH_CFG), 32'h0);
		wr(cha(19, CH_LIMIT), 32'h7);
		smpl(7, 7, 7);
		chk_out(8'h00, dout);
		rchk(cha(19, CH_CFG), cfgw(WCB_OP_NE, WCB_SRC_GROSS, 5'd8));
		$display("test outputs done");
		// Rate channel needs both calculation and display
		wr(A_CTRL, 32'h3);
		wr(A_RATE_PER, 32'h4);
		wr(A_RATE_AVG, 32'h1);
		wr(cha(4, CH_LIMIT), 32'd20);
		wr(cha(4, CH_CFG), cfgw(WCB_OP_GE, WCB_SRC_RATE, 5'd2));
		ramp();
		chk_out(8'h00, dout & 8'h02);
		wr(A_CTRL, 32'h7);
		ramp();
		chk_out(8'h02, dout & 8'h02);
		rchk(A_RATE_VAL, 32'd20);
		$display("test rate done");
		// Target table load, miss, edit, escape, accept
		wr(A_CTRL, 32'h1);
		wr(A_IRQ_EN, 32'h7);
		wr(A_TBL_SEL, 32'h0);
		for (int i = 0; i < 5; i++)
			wr(A_TBLF_BASE + 10'(4 * i), 32'h100 + i);
		wr(A_TBL_ID, 32'h103);
		wr(A_IRQ_CLR, 32'hf);
		wr(A_TGT_CMD, 32'h0304);
		rd(A_IRQ_ST, d);
		chk_reg(32'h2, d & 32'h7);
		rchk(A_ACT_BASE + 10'h10, 32'h104);
		chk_out(8'h01, {7'h0, irq});
		wr(A_IRQ_CLR, 32'hf);
		wr(A_TGT_CMD, 32'h0904);
		rd(A_IRQ_ST, d);
		chk_reg(32'h1, d & 32'h7);
		rchk(A_TGT_ACT_ID, 32'h3);
		wr(A_PEND_BASE, 32'h55);
		rchk(A_ACT_BASE, 32'h100);
		wr(A_TGT_CMD, 32'h2);
		rchk(A_PEND_BASE, 32'h100);
		wr(A_PEND_BASE, 32'h66);
		wr(A_PEND_BASE + 10'h4, 32'h77);
		wr(A_TGT_CMD, 32'h1);
		rd(A_IRQ_ST, d);
		chk_reg(32'h4, d & 32'h4);
		rchk(A_ACT_BASE + 10'h4, 32'h77);
		wr(A_TGT_MODE, 32'h2);
		wr(A_TGT_CMD, 32'h0304);
		rchk(A_ACT_BASE + 10'h8, 32'h0);
		rchk(A_ACT_BASE + 10'h4, 32'h101);
		$display("test target done");
		// Masked interrupt and unmapped address
		wr(A_IRQ_EN, 32'h0);
		repeat (3) @(posedge clk_sys_in) req <= '0;
		chk_out(8'h00, {7'h0, irq});
		wr(10'h3fc, 32'hffffffff);
		rchk(10'h3fc, 32'h0);
		rchk(A_IRQ_CLR, 32'h0);
		rchk(A_TGT_CMD, 32'h0);
		$display("test misc done");
		// Mid-run reset clears outputs, interrupt, record and configuration
		wr(A_IRQ_EN, 32'h8);
		wr(cha(5, CH_CFG), cfgw(WCB_OP_GE, WCB_SRC_GROSS, 5'd3));
		smpl(7, 7, 7);
		chk_out(8'h04, dout);
		chk_out(8'h01, {7'h0, irq});
		@(posedge clk_sys_in);
		srst_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		#1;
		chk_out(8'h00, dout);
		chk_out(8'h00, {7'h0, irq});
		rchk(A_TGT_ACT_ID, 32'h0);
		rchk(cha(5, CH_CFG), 32'h0);
		$display("test reset done");
		final_report();
	end
endmodule
